// ==== design/csrc_defines.vh ====
`ifndef CSRC_DEFINES_VH
`define CSRC_DEFINES_VH
`define CSRC_ADDR_MAIN      8'h00
`define CSRC_ADDR_DIST      8'h04
`define CSRC_ADDR_WAKE      8'h08
`define CSRC_ADDR_TRIM      8'h0C
`define CSRC_ADDR_SLOW      8'h10
`define CSRC_ADDR_XCFG      8'h14
`define CSRC_ADDR_XCSR      8'h18
`define CSRC_ADDR_STAT      8'h1C
`define CSRC_FSEL_HI        2
`define CSRC_FSEL_LO        0
`define CSRC_DBL_EN         4
`define CSRC_DBL_ALT        5
`define CSRC_DIST_ALTSRC    6
`define CSRC_DIST_MAIN_HI   5
`define CSRC_DIST_MAIN_LO   4
`define CSRC_DIST_SLOW_HI   3
`define CSRC_DIST_SLOW_LO   2
`define CSRC_SLOW_EN1K      1
`define CSRC_SLOW_EN100K    2
`define CSRC_SLOW_PDM       4
`define CSRC_SLOW_DIV3      5
`define CSRC_XTAL_EN        0
`define CSRC_XCFG_HI        4
`define CSRC_TRIM_HI        7
`define CSRC_TRIM_LO        6
`define CSRC_MAIN_RST       8'h02
`define CSRC_DIST_RST       8'h00
`define CSRC_SLOW_RST       8'h06
`define CSRC_TRIM_RST       8'h00
`define CSRC_FAST_START_NS  1000
`define CSRC_CLK_NS         8
`endif

// ==== design/csrc_clk_div.v ====
`timescale 1ns/1ps
// toggles output each time count reaches half period; held low when disabled
module csrc_clk_div #(
    parameter CW   = 16,
    parameter HALF = 4
) (
    input  wire          clk,
    input  wire          arst_n,
    input  wire          ce,
    input  wire          en,
    output reg           clkOut
);
    reg [CW-1:0] count;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count  <= {CW{1'b0}};
            clkOut <= 1'b0;
        end
        else if (ce)
        begin
            if (!en)
            begin
                count  <= {CW{1'b0}};
                clkOut <= 1'b0;
            end
            else if (count == HALF[CW-1:0] - 1'b1)
            begin
                count  <= {CW{1'b0}};
                clkOut <= ~clkOut;
            end
            else
            begin
                count <= count + 1'b1;
            end
        end
    end
endmodule

// ==== design/csrc_div3.v ====
`timescale 1ns/1ps
// divide-by-3 by edge counting of the source, output low when disabled
module csrc_div3 (
    input  wire          clk,
    input  wire          arst_n,
    input  wire          ce,
    input  wire          en,
    input  wire          src,
    output reg           clkOut
);
    reg       srcPrev;
    reg [1:0] edges;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            srcPrev <= 1'b0;
            edges   <= 2'b00;
            clkOut  <= 1'b0;
        end
        else if (ce)
        begin
            srcPrev <= src;
            if (!en)
            begin
                edges  <= 2'b00;
                clkOut <= 1'b0;
            end
            else if (src != srcPrev)
            begin
                if (edges == 2'b10)
                begin
                    edges  <= 2'b00;
                    clkOut <= ~clkOut;
                end
                else
                begin
                    edges <= edges + 2'b01;
                end
            end
        end
    end
endmodule

// ==== design/csrc_top.v ====
`timescale 1ns/1ps
`include "csrc_defines.vh"
// oscillators are modelled as counters on clk; real analog sources are not synthesizable
module csrc_top #(
    parameter MAIN_HALF  = 4,
    parameter XTAL_HALF  = 6,
    parameter SLOW1_HALF = 62500,
    parameter SLOW2_HALF = 625,
    parameter DIVW       = 17
) (
    input  wire          clk,
    input  wire          arst_n,
    input  wire          ce,
    input  wire          hsel,
    input  wire [31:0]   haddr,
    input  wire [1:0]    htrans,
    input  wire          hwrite,
    input  wire [2:0]    hsize,
    input  wire [31:0]   hwdata,
    input  wire          hready,
    output reg  [31:0]   hrdata,
    output reg           hreadyout,
    output reg           hresp,
    input  wire          hibernate,
    input  wire          wakeStart,
    input  wire          bootStart,
    input  wire [1:0]    bootTrimLatch,
    input  wire          bootSpeedLatch,
    input  wire          doublerAltInput,
    output reg           mainClock,
    output reg           doubledClock,
    output reg           mainDistClock,
    output reg           slowDistClock,
    output reg           slow1khzClock,
    output reg           slow100khzClock,
    output reg           slow33khzClock,
    output reg           crystalClock,
    output reg  [2:0]    mainFreqSel,
    output reg  [7:0]    mainTrimHigh,
    output reg           fastBias,
    output reg           mainReady,
    output reg           slowPowerDown,
    output reg  [4:0]    crystalConfig
);
    localparam integer FAST_CYC = `CSRC_FAST_START_NS / `CSRC_CLK_NS;

    reg [7:0] mainCtl;
    reg [7:0] distCtl;
    reg [7:0] wakeTrim;
    reg [7:0] slowCtl;
    reg [7:0] xCfg;
    reg [7:0] xCsr;
    reg       aPend;
    reg       aWrite;
    reg [7:0] aAddr;
    reg [7:0] startCnt;
    reg       starting;

    wire      en1k   = slowCtl[`CSRC_SLOW_EN1K] & ~hibernate;
    wire      en100k = slowCtl[`CSRC_SLOW_EN100K] & ~hibernate;
    wire      xEn    = xCsr[`CSRC_XTAL_EN];
    wire      mainRaw;
    wire      xRaw;
    wire      s1k;
    wire      s100k;
    wire      s33k;
    reg       dblSrc;
    reg       dblPrev;
    reg       next_mainDist;
    reg       next_slowDist;

    // main oscillator model, held low during wake start until mainReady returns
    csrc_clk_div #(.CW(DIVW), .HALF(MAIN_HALF)) uMain (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .en     (mainReady),
        .clkOut (mainRaw)
    );
    csrc_clk_div #(.CW(DIVW), .HALF(XTAL_HALF)) uXtal (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .en     (xEn),
        .clkOut (xRaw)
    );
    csrc_clk_div #(.CW(DIVW), .HALF(SLOW1_HALF)) uSlow1 (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .en     (en1k),
        .clkOut (s1k)
    );
    csrc_clk_div #(.CW(DIVW), .HALF(SLOW2_HALF)) uSlow2 (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .en     (en100k),
        .clkOut (s100k)
    );
    csrc_div3 uDiv3 (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .en     (slowCtl[`CSRC_SLOW_DIV3] & en100k),
        .src    (s100k),
        .clkOut (s33k)
    );

    always @*
    begin
        if (!mainCtl[`CSRC_DBL_ALT])
            dblSrc = mainRaw;
        else if (distCtl[`CSRC_DIST_ALTSRC])
            dblSrc = xRaw;
        else
            dblSrc = doublerAltInput;
    end

    always @*
    begin
        case (distCtl[`CSRC_DIST_MAIN_HI:`CSRC_DIST_MAIN_LO])
            2'b00:   next_mainDist = mainRaw;
            2'b01:   next_mainDist = doubledClock;
            default: next_mainDist = 1'b0;
        endcase
    end

    always @*
    begin
        case (distCtl[`CSRC_DIST_SLOW_HI:`CSRC_DIST_SLOW_LO])
            2'b00:   next_slowDist = s1k;
            2'b01:   next_slowDist = s100k;
            2'b10:   next_slowDist = s33k;
            default: next_slowDist = 1'b0;
        endcase
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dblPrev         <= 1'b0;
            doubledClock    <= 1'b0;
            mainClock       <= 1'b0;
            mainDistClock   <= 1'b0;
            slowDistClock   <= 1'b0;
            slow1khzClock   <= 1'b0;
            slow100khzClock <= 1'b0;
            slow33khzClock  <= 1'b0;
            crystalClock    <= 1'b0;
            mainFreqSel     <= 3'b000;
            mainTrimHigh    <= 8'h00;
            slowPowerDown   <= 1'b0;
            crystalConfig   <= 5'b0_0000;
        end
        else if (ce)
        begin
            dblPrev <= dblSrc;
            // doubler: pulse per source edge, except an edge on the cycle right after a pulse; only while enabled
            doubledClock    <= mainCtl[`CSRC_DBL_EN] & (dblSrc ^ dblPrev) & ~doubledClock;
            mainClock       <= mainRaw;
            mainDistClock   <= next_mainDist;
            slowDistClock   <= next_slowDist;
            slow1khzClock   <= s1k;
            slow100khzClock <= s100k;
            slow33khzClock  <= s33k;
            crystalClock    <= xRaw;
            mainFreqSel     <= fastBias ? wakeTrim[`CSRC_FSEL_HI:`CSRC_FSEL_LO]
                                        : mainCtl[`CSRC_FSEL_HI:`CSRC_FSEL_LO];
            mainTrimHigh    <= wakeTrim;
            slowPowerDown   <= slowCtl[`CSRC_SLOW_PDM];
            crystalConfig   <= xCfg[`CSRC_XCFG_HI:0];
        end
    end

    // wake sequencing: fast bias from wakeStart until one cycle after mainReady returns
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            startCnt  <= 8'h00;
            starting  <= 1'b0;
            fastBias  <= 1'b0;
            mainReady <= 1'b1;
        end
        else if (ce)
        begin
            if (wakeStart)
            begin
                starting  <= 1'b1;
                startCnt  <= 8'h00;
                fastBias  <= 1'b1;
                mainReady <= 1'b0;
            end
            else if (starting)
            begin
                // clock within 1 us
                // one cycle early: ready registers one edge late
                if (startCnt == FAST_CYC[7:0] - 8'h02)
                begin
                    starting  <= 1'b0;
                    mainReady <= 1'b1;
                end
                startCnt <= startCnt + 8'h01;
            end
            else if (mainReady)
            begin
                fastBias <= 1'b0;
            end
        end
    end

    // ahb-lite slave, zero wait states
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aPend     <= 1'b0;
            aWrite    <= 1'b0;
            aAddr     <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            mainCtl   <= `CSRC_MAIN_RST;
            distCtl   <= `CSRC_DIST_RST;
            wakeTrim  <= `CSRC_TRIM_RST;
            slowCtl   <= `CSRC_SLOW_RST;
            xCfg      <= 8'h00;
            xCsr      <= 8'h00;
        end
        else if (ce)
        begin
            if (aPend && aWrite)
            begin
                if (aAddr == `CSRC_ADDR_MAIN)
                    mainCtl <= hwdata[7:0];
                else if (aAddr == `CSRC_ADDR_DIST)
                    distCtl <= hwdata[7:0];
                else if (aAddr == `CSRC_ADDR_WAKE)
                    wakeTrim <= hwdata[7:0];
                else if (aAddr == `CSRC_ADDR_SLOW)
                    slowCtl <= hwdata[7:0];
                else if (aAddr == `CSRC_ADDR_XCFG)
                    xCfg <= hwdata[7:0];
                else if (aAddr == `CSRC_ADDR_XCSR)
                    xCsr <= hwdata[7:0];
            end
            if (bootStart)
            begin
                // speed latch sets select msb: 12 or 48 MHz
                mainCtl[`CSRC_FSEL_HI:`CSRC_FSEL_LO] <= {bootSpeedLatch, 2'b10};
                wakeTrim[`CSRC_TRIM_HI:`CSRC_TRIM_LO] <= bootTrimLatch;
            end
            aPend  <= hsel & htrans[1] & hready;
            aWrite <= hwrite;
            aAddr  <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite)
            begin
                if (haddr[7:0] == `CSRC_ADDR_MAIN)
                    hrdata <= {24'h00_0000, mainCtl};
                else if (haddr[7:0] == `CSRC_ADDR_DIST)
                    hrdata <= {24'h00_0000, distCtl};
                else if (haddr[7:0] == `CSRC_ADDR_WAKE)
                    hrdata <= {24'h00_0000, wakeTrim};
                else if (haddr[7:0] == `CSRC_ADDR_TRIM)
                    hrdata <= {24'h00_0000, mainTrimHigh};
                else if (haddr[7:0] == `CSRC_ADDR_SLOW)
                    hrdata <= {24'h00_0000, slowCtl};
                else if (haddr[7:0] == `CSRC_ADDR_XCFG)
                    hrdata <= {24'h00_0000, xCfg};
                else if (haddr[7:0] == `CSRC_ADDR_XCSR)
                    hrdata <= {24'h00_0000, xCsr};
                else if (haddr[7:0] == `CSRC_ADDR_STAT)
                    hrdata <= {26'h000_0000, hibernate, xEn, mainFreqSel[2], fastBias,
                               mainReady, 1'b1};
                else
                    hrdata <= 32'h0000_0000;
            end
        end
    end
endmodule

// ==== test/csrc_assertions.sv ====
`timescale 1ns/1ps
module csrc_assertions #(
    parameter SLOW1_HALF = 62500,
    parameter SLOW2_HALF = 625
) (
    input wire       clk,
    input wire       arst_n,
    input wire       hibernate,
    input wire       wakeStart,
    input wire       bootStart,
    input wire [1:0] bootTrimLatch,
    input wire       bootSpeedLatch,
    input wire       slow1khzClock,
    input wire       slow100khzClock,
    input wire       slow33khzClock,
    input wire [2:0] mainFreqSel,
    input wire [7:0] mainTrimHigh,
    input wire       fastBias,
    input wire       mainReady
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // high-phase run lengths; one cycle of slack for the divider's count origin
    reg [17:0] run1;
    reg [17:0] run2;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            run1 <= 18'h0_0000;
            run2 <= 18'h0_0000;
        end
        else
        begin
            run1 <= slow1khzClock ? run1 + 18'h0_0001 : 18'h0_0000;
            run2 <= slow100khzClock ? run2 + 18'h0_0001 : 18'h0_0000;
        end
    end
    property p_hib_slow;
        hibernate && $past(hibernate) && $past(hibernate, 2)
            |-> !slow1khzClock && !slow100khzClock && !slow33khzClock;
    endproperty
    a_hib_slow: assert property (p_hib_slow) else $error("slow clock in hibernate");
    property p_wake_back;
        wakeStart |-> ##[1:125] mainReady;
    endproperty
    a_wake_back: assert property (p_wake_back) else $error("no clock after wake");
    property p_bias_cause;
        $rose(fastBias) |-> wakeStart || $past(wakeStart);
    endproperty
    a_bias_cause: assert property (p_bias_cause) else $error("fast bias without wake");
    property p_bias_ends;
        fastBias |-> ##[1:130] !fastBias;
    endproperty
    a_bias_ends: assert property (p_bias_ends) else $error("fast bias stuck");
    property p_boot_sel;
        bootStart && !wakeStart && !fastBias |-> ##2 mainFreqSel == {$past(bootSpeedLatch, 2), 2'b10};
    endproperty
    a_boot_sel: assert property (p_boot_sel) else $error("boot select wrong");
    property p_boot_trim;
        bootStart |-> ##2 mainTrimHigh[7:6] == $past(bootTrimLatch, 2);
    endproperty
    a_boot_trim: assert property (p_boot_trim) else $error("boot trim wrong");
    property p_run1k;
        run1 <= SLOW1_HALF + 1;
    endproperty
    a_run1k: assert property (p_run1k) else $error("1k clock stuck high");
    property p_run100k;
        run2 <= SLOW2_HALF + 1;
    endproperty
    a_run100k: assert property (p_run100k) else $error("100k clock stuck high");
endmodule
bind csrc_top csrc_assertions #(.SLOW1_HALF(SLOW1_HALF), .SLOW2_HALF(SLOW2_HALF)) csrc_assertions_i (
    .clk(clk), .arst_n(arst_n), .hibernate(hibernate), .wakeStart(wakeStart),
    .bootStart(bootStart), .bootTrimLatch(bootTrimLatch), .bootSpeedLatch(bootSpeedLatch),
    .slow1khzClock(slow1khzClock), .slow100khzClock(slow100khzClock),
    .slow33khzClock(slow33khzClock), .mainFreqSel(mainFreqSel), .mainTrimHigh(mainTrimHigh),
    .fastBias(fastBias), .mainReady(mainReady));

// ==== test/test_clock_source_selection.sv ====
`timescale 1ns/1ps
module test_clock_source_selection;
    reg         clk = 1'b0;
    reg         arst_n = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0000_0000;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0000_0000;
    reg         hibernate = 1'b0;
    reg         wakeStart = 1'b0;
    reg         bootStart = 1'b0;
    reg  [1:0]  bootTrimLatch = 2'h0;
    reg         bootSpeedLatch = 1'b0;
    reg         doublerAltInput = 1'b0;
    reg         altRun = 1'b0;
    reg  [31:0] rd;
    wire [31:0] hrdata;
    wire        hreadyout;
    wire        hresp;
    wire [7:0]  clks;
    wire [2:0]  mainFreqSel;
    wire [7:0]  mainTrimHigh;
    wire        fastBias;
    wire        mainReady;
    wire        slowPowerDown;
    wire [4:0]  crystalConfig;
    integer     n_errors = 0;
    integer     check_count = 0;
    integer     i;
    csrc_top #(.SLOW1_HALF(8), .SLOW2_HALF(4)) csrc_top_i (
        .clk(clk), .arst_n(arst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .hibernate(hibernate), .wakeStart(wakeStart),
        .bootStart(bootStart), .bootTrimLatch(bootTrimLatch), .bootSpeedLatch(bootSpeedLatch),
        .doublerAltInput(doublerAltInput), .mainClock(clks[7]), .doubledClock(clks[6]),
        .mainDistClock(clks[5]), .slowDistClock(clks[4]), .slow1khzClock(clks[3]),
        .slow100khzClock(clks[2]), .slow33khzClock(clks[1]), .crystalClock(clks[0]),
        .mainFreqSel(mainFreqSel), .mainTrimHigh(mainTrimHigh), .fastBias(fastBias),
        .mainReady(mainReady), .slowPowerDown(slowPowerDown), .crystalConfig(crystalConfig));
    always #4 clk = ~clk;
    always @(posedge clk)
        if (altRun)
            doublerAltInput <= ~doublerAltInput;
    task check(input [31:0] seen, input [31:0] expd);
    begin
        check_count = check_count + 1;
        if (seen !== expd)
        begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, seen, expd);
        end
    end
    endtask
    task bus(input w, input [7:0] a, input [31:0] wd);
    begin
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    end
    endtask
    // rising edges of one modelled clock over a window; first cycles skipped for latency
    task act(input integer idx, input e);
        integer n;
        reg     last;
    begin
        n = 0;
        repeat (4) @(posedge clk);
        last = clks[idx];
        repeat (100)
        begin
            @(posedge clk);
            if (clks[idx] && !last)
                n = n + 1;
            last = clks[idx];
        end
        check({31'h0, n != 0}, {31'h0, e});
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    initial
    begin
        repeat (30000) @(posedge clk);
        n_errors = n_errors + 1;
        test_done;
    end
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 7; i = i + 1)
        begin
            bus(1'b0, {i[5:0], 2'b00}, 32'h0);
            check(rd, i == 0 ? 32'h0000_0002 : i == 4 ? 32'h0000_0006 : 32'h0000_0000);
        end
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0000_0000);
        check(hresp, 1'b0);
        bus(1'b1, 8'h00, 32'h0000_0005);
        act(6, 1'b0);
        check(mainFreqSel, 3'h5);
        act(7, 1'b1);
        bus(1'b1, 8'h00, 32'h0000_0015);
        act(6, 1'b1);
        for (i = 0; i < 3; i = i + 1)
        begin
            bus(1'b1, 8'h04, {26'h0, i[1:0], 4'h0});
            act(5, i != 2);
        end
        bus(1'b1, 8'h04, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_0035);
        act(6, 1'b0);
        altRun <= 1'b1;
        act(6, 1'b1);
        altRun <= 1'b0;
        bus(1'b1, 8'h04, 32'h0000_0040);
        bus(1'b1, 8'h18, 32'h0000_0001);
        act(0, 1'b1);
        act(6, 1'b1);
        bus(1'b1, 8'h18, 32'h0000_0000);
        act(0, 1'b0);
        act(6, 1'b0);
        bus(1'b1, 8'h10, 32'h0000_0000);
        act(3, 1'b0);
        act(2, 1'b0);
        bus(1'b1, 8'h10, 32'h0000_0002);
        act(3, 1'b1);
        act(2, 1'b0);
        bus(1'b1, 8'h10, 32'h0000_0024);
        act(3, 1'b0);
        act(1, 1'b1);
        bus(1'b1, 8'h10, 32'h0000_0006);
        act(1, 1'b0);
        bus(1'b1, 8'h10, 32'h0000_0026);
        for (i = 0; i < 4; i = i + 1)
        begin
            bus(1'b1, 8'h04, {28'h0, i[1:0], 2'b00});
            act(4, i != 3);
        end
        hibernate <= 1'b1;
        act(3, 1'b0);
        act(2, 1'b0);
        act(1, 1'b0);
        hibernate <= 1'b0;
        bus(1'b1, 8'h10, 32'h0000_0016);
        repeat (2) @(posedge clk);
        check(slowPowerDown, 1'b1);
        bus(1'b1, 8'h14, 32'hFFFF_FFFF);
        repeat (2) @(posedge clk);
        check(crystalConfig, 5'h1F);
        bus(1'b0, 8'h14, 32'h0);
        check(rd & 32'hFFFF_FF00, 32'h0000_0000);
        for (i = 0; i < 2; i = i + 1)
        begin
            bootSpeedLatch <= i[0];
            bootTrimLatch <= {~i[0], i[0]};
            bootStart <= 1'b1;
            @(posedge clk);
            bootStart <= 1'b0;
            repeat (3) @(posedge clk);
            check(mainFreqSel, {i[0], 2'b10});
            bus(1'b0, 8'h0C, 32'h0);
            check(rd[7:6], {~i[0], i[0]});
        end
        bus(1'b1, 8'h08, 32'h0000_0003);
        bus(1'b1, 8'h00, 32'h0000_0005);
        wakeStart <= 1'b1;
        @(posedge clk);
        wakeStart <= 1'b0;
        repeat (2) @(posedge clk);
        check(fastBias, 1'b1);
        check(mainFreqSel, 3'h3);
        for (i = 0; i < 130 && mainReady !== 1'b1; i = i + 1) @(posedge clk);
        check(mainReady, 1'b1);
        for (i = 0; i < 130 && fastBias !== 1'b0; i = i + 1) @(posedge clk);
        repeat (2) @(posedge clk);
        check(fastBias, 1'b0);
        check(mainFreqSel, 3'h5);
        test_done;
    end
endmodule
